/* src/imu_cmd_handler.sv */
// Configuration command handler: decoded commands arrive over APB, config held here.
// Assumes the serial layer feeds each command character to CHAR and hands over a
// decoded opcode, argument count, received checksum and binary arguments.
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module imu_cmd_handler
   import imu_cmd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [31:0] err_event,
   input wire logic flash_fault,
   output mode_t mode,
   output cfg_t cfg,
   output logic flash_write,
   output logic volt_3v3,
   output logic strobe_en,
   output logic trim_report_en
);
   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [7:0] ch);
      logic [7:0] r;
      r = c ^ ch;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   function automatic logic [3:0] args_needed(input logic [7:0] op);
      case (op)
         OP_SET, OP_TRIM_ADJ, OP_TRIM_SET, OP_SVC_AUX, OP_SVC_SYSCFG: return 4'h2;
         OP_QUERY, OP_REF_SET, OP_SVC_EXIT: return 4'h1;
         default: return 4'h0;
      endcase
   endfunction

   function automatic logic [15:0] trim_limit(input logic [3:0] idx);
      return (idx < 4'h3) ? TRIM_LIM_GYRO : (idx < 4'h6) ? TRIM_LIM_ACC : TRIM_LIM_INC;
   endfunction

   // ************************************************************
   // Bus side
   // ************************************************************
   logic [7:0] crc;
   logic dollar_seen;
   logic [7:0] cmd_op;
   logic [7:0] cmd_crc;
   logic [3:0] cmd_cnt;
   logic [31:0] arg0;
   logic [31:0] arg1;
   logic go;
   logic [3:0] status;
   logic [31:0] result;
   logic [31:0] err_log;
   logic [15:0] saves_left;
   cfg_t stored;
   logic load_pending;
   logic leave_pending;
   mode_t leave_target;
   logic mapped;
   logic wr_en;
   logic [31:0] next_rdata;

   assign mapped = (paddr == OFF_CMD) || (paddr == OFF_ARG0) || (paddr == OFF_ARG1) ||
      (paddr == OFF_CHAR) || (paddr == OFF_STATUS) || (paddr == OFF_RESULT) ||
      (paddr == OFF_ERRIN) || (paddr == OFF_SAVES);
   assign wr_en = psel && penable && pwrite && pready;

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (paddr)
         OFF_CMD: next_rdata = {12'h000, cmd_cnt, cmd_crc, cmd_op};
         OFF_ARG0: next_rdata = arg0;
         OFF_ARG1: next_rdata = arg1;
         OFF_STATUS: next_rdata = {15'h0000, go, crc, 2'b00, mode, status};
         OFF_RESULT: next_rdata = result;
         OFF_ERRIN: next_rdata = err_log;
         OFF_SAVES: next_rdata = {16'h0000, saves_left};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Answer always in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         prdata <= (psel && !penable && !pwrite) ? next_rdata : 32'h0000_0000;
         pslverr <= psel && !penable && !mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_op <= 8'h00;
         cmd_crc <= 8'h00;
         cmd_cnt <= 4'h0;
         arg0 <= 32'h0000_0000;
         arg1 <= 32'h0000_0000;
      end else if (wr_en && mapped) begin
         if (paddr == OFF_CMD) begin
            cmd_op <= pwdata[7:0];
            cmd_crc <= pwdata[CMD_CRC_LSB +: 8];
            cmd_cnt <= pwdata[CMD_CNT_LSB +: 4];
         end
         if (paddr == OFF_ARG0) arg0 <= pwdata;
         if (paddr == OFF_ARG1) arg1 <= pwdata;
      end
   end

   // Running checksum over start character through last comma
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc <= CRC_SEED;
         dollar_seen <= 1'b0;
      end else if (wr_en && paddr == OFF_CHAR) begin
         if (pwdata[CHAR_START_BIT]) begin
            crc <= crc8_step(CRC_SEED, pwdata[7:0]);
            dollar_seen <= (pwdata[7:0] == CHAR_DOLLAR);
         end else begin
            crc <= crc8_step(crc, pwdata[7:0]);
         end
      end
   end

   // A command write starts one execute cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) go <= 1'b0;
      else go <= wr_en && paddr == OFF_CMD;
   end

   // ************************************************************
   // Command execution
   // ************************************************************
   logic [3:0] chk;
   logic known;
   logic mode_ok;
   logic [4:0] fsel;
   logic [3:0] tidx;
   logic signed [16:0] tsum;
   logic signed [16:0] tlim;
   logic clamp_hi;
   logic clamp_lo;

   assign fsel = arg0[4:0];
   assign tidx = arg1[3:0];
   assign tlim = {1'b0, trim_limit(tidx)};
   assign tsum = $signed({cfg.trim[tidx][15], cfg.trim[tidx]}) + $signed({arg0[15], arg0[15:0]});
   assign clamp_hi = tsum > tlim;
   assign clamp_lo = tsum < -tlim;

   always_comb begin
      known = 1'b1;
      mode_ok = (mode == MODE_MACHINE);
      case (cmd_op)
         OP_ENTRY, OP_SVC_ENTRY: mode_ok = 1'b1;
         OP_SVC_AUX, OP_SVC_SAVE, OP_SVC_EXIT, OP_SVC_RESTORE, OP_SVC_SYSCFG:
            mode_ok = (mode == MODE_SERVICE);
         OP_QUERY, OP_ERRLOG, OP_SAVE, OP_SAVES_LEFT, OP_LEAVE, OP_SET, OP_TRIM_READ,
            OP_TRIM_ADJ, OP_TRIM_SET, OP_REF_READ, OP_REF_SET: mode_ok = mode_ok;
         default: known = 1'b0;
      endcase
   end

   // Parameter check by command and field
   function automatic logic param_bad(input logic [7:0] op, input logic [4:0] f,
      input logic [31:0] a0, input logic [31:0] a1, input logic [3:0] ti);
      logic bad;
      bad = 1'b0;
      case (op)
         OP_SET: begin
            case (f)
               F_RATE: bad = a1 > 32'd5;
               F_GFILT, F_AFILT, F_IFILT, F_UFILT: bad = a1 > 32'd4;
               F_GUNIT: bad = (a1 > 32'd11) || (a1[3:2] == 2'b01);
               F_AUNIT, F_IUNIT: bad = a1 > 32'd3;
               F_GCOMP: bad = a1 > 32'd12;
               F_SYSCFG: bad = a1 > 32'd7;
               F_DGRAM, F_AUX: bad = 1'b0;
               default: bad = 1'b1;
            endcase
         end
         OP_QUERY: bad = !(f <= F_AUX || (f >= F_SERIAL && f <= F_TX));
         OP_TRIM_ADJ, OP_TRIM_SET: bad = ti > 4'h8;
         OP_SVC_EXIT: bad = !(a0[7:0] == EXIT_N || a0[7:0] == EXIT_I ||
            a0[7:0] == EXIT_N_NOW || a0[7:0] == EXIT_I_NOW);
         OP_SVC_SYSCFG: bad = !(a0[7:0] == SYS_VOLT || a0[7:0] == SYS_TOV ||
            a0[7:0] == SYS_BTO) || a1 > 32'd1;
         default: bad = 1'b0;
      endcase
      return bad;
   endfunction

   // Lowest failing check wins
   always_comb begin
      if (!dollar_seen || !mode_ok) chk = ST_INVALID;
      else if (cmd_crc != crc) chk = ST_BAD_CRC;
      else if (!known) chk = ST_UNKNOWN;
      else if (cmd_cnt != args_needed(cmd_op)) chk = ST_PCOUNT;
      else if (param_bad(cmd_op, fsel, arg0, arg1, tidx)) chk = ST_BAD_PARAM;
      else chk = ST_OK;
   end

   function automatic logic [31:0] query_value(input cfg_t c, input logic [4:0] f);
      case (f)
         F_RATE: return {29'h0, c.rate};
         F_GFILT: return {29'h0, c.gfilt};
         F_AFILT: return {29'h0, c.afilt};
         F_IFILT: return {29'h0, c.ifilt};
         F_UFILT: return {29'h0, c.ufilt};
         F_DGRAM: return {24'h0, c.dgram};
         F_GUNIT: return {28'h0, c.gunit};
         F_AUNIT: return {28'h0, c.aunit};
         F_IUNIT: return {28'h0, c.iunit};
         F_GCOMP: return {28'h0, c.gcomp};
         F_SYSCFG: return {29'h0, c.bto_en, c.tov_en, c.volt_3v3};
         F_AUX: return {c.aux_k1, c.aux_k2};
         F_SERIAL: return ID_SERIAL;
         F_NAME: return ID_NAME;
         F_PART: return ID_PART;
         F_HW: return ID_HW;
         F_FW: return ID_FW;
         F_AXES: return ID_AXES;
         F_RANGES: return ID_RANGES;
         F_TX: return ID_TX;
         default: return 32'h0000_0000;
      endcase
   endfunction

   // Status and result; the response text is built from these by the serial layer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= ST_OK;
         result <= 32'h0000_0000;
      end else if (go) begin
         status <= chk;
         result <= 32'h0000_0000;
         if (chk == ST_OK) begin
            case (cmd_op)
               OP_ENTRY: result <= ENTRY_ACK_CRC;
               OP_QUERY: result <= query_value(cfg, fsel);
               OP_ERRLOG: result <= err_log;
               OP_SAVES_LEFT: result <= {16'h0000, saves_left};
               OP_TRIM_READ: result <= {cfg.trim[tidx], 16'h0000} | {16'h0000, cfg.trim[0]};
               OP_REF_READ: result <= cfg.ref_info;
               OP_SAVE, OP_SVC_SAVE: begin
                  // Save goes ahead even past the limit; status only warns
                  if (saves_left == 16'h0000) status <= ST_SAVE_LIMIT;
                  else if (flash_fault) status <= ST_SAVE_ERR;
                  result <= {16'h0000, (saves_left == 16'h0000) ? 16'h0000 : saves_left - 16'h0001};
               end
               OP_TRIM_ADJ: begin
                  if (clamp_hi || clamp_lo) status <= ST_CLAMPED;
                  result <= {16'h0000, cfg.trim[tidx]};
               end
               default: result <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Errors accumulate until read; a new event in the read cycle is kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) err_log <= 32'h0000_0000;
      else if (go && chk == ST_OK && cmd_op == OP_ERRLOG) err_log <= err_event;
      else err_log <= err_log | err_event;
   end

   // ************************************************************
   // Volatile configuration and flash copy
   // ************************************************************
   // The flash copy is a register here: it survives the soft reloads, not a power cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stored <= CFG_FACTORY;
         saves_left <= SAVES_RESET;
         flash_write <= 1'b0;
      end else begin
         flash_write <= 1'b0;
         if (go && chk == ST_OK && (cmd_op == OP_SAVE || cmd_op == OP_SVC_SAVE)) begin
            flash_write <= 1'b1;
            if (!flash_fault) stored <= cfg;
            if (saves_left != 16'h0000) saves_left <= saves_left - 16'h0001;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= CFG_FACTORY;
         load_pending <= 1'b1;
      end else if (load_pending) begin
         cfg <= stored;
         load_pending <= 1'b0;
      end else if (leave_pending && leave_target == MODE_INIT) begin
         cfg <= stored;
      end else if (go && chk == ST_OK) begin
         case (cmd_op)
            OP_SET: begin
               case (fsel)
                  F_RATE: cfg.rate <= arg1[2:0];
                  F_GFILT: cfg.gfilt <= arg1[2:0];
                  F_AFILT: cfg.afilt <= arg1[2:0];
                  F_IFILT: cfg.ifilt <= arg1[2:0];
                  F_UFILT: cfg.ufilt <= arg1[2:0];
                  F_DGRAM: cfg.dgram <= arg1[7:0];
                  F_GUNIT: cfg.gunit <= arg1[3:0];
                  F_AUNIT: cfg.aunit <= arg1[3:0];
                  F_IUNIT: cfg.iunit <= arg1[3:0];
                  F_GCOMP: cfg.gcomp <= arg1[3:0];
                  F_SYSCFG: {cfg.bto_en, cfg.tov_en, cfg.volt_3v3} <= arg1[2:0];
                  default: {cfg.aux_k1, cfg.aux_k2} <= arg1;
               endcase
            end
            OP_SVC_AUX: begin
               cfg.aux_k1 <= arg0[15:0];
               cfg.aux_k2 <= arg1[15:0];
            end
            OP_SVC_SYSCFG: begin
               if (arg0[7:0] == SYS_VOLT) cfg.volt_3v3 <= arg1[0];
               if (arg0[7:0] == SYS_TOV) cfg.tov_en <= arg1[0];
               if (arg0[7:0] == SYS_BTO) cfg.bto_en <= arg1[0];
            end
            OP_SVC_RESTORE: cfg <= CFG_FACTORY;
            OP_TRIM_SET: cfg.trim[tidx] <= arg0[15:0];
            OP_TRIM_ADJ: begin
               if (clamp_hi) cfg.trim[tidx] <= tlim[15:0];
               else if (clamp_lo) cfg.trim[tidx] <= 16'h0000 - tlim[15:0];
               else cfg.trim[tidx] <= tsum[15:0];
            end
            OP_REF_SET: cfg.ref_info <= arg0;
            default: cfg <= cfg;
         endcase
      end
   end

   // Pins follow the volatile settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         volt_3v3 <= 1'b0;
         strobe_en <= 1'b0;
         trim_report_en <= 1'b0;
      end else begin
         volt_3v3 <= cfg.volt_3v3;
         strobe_en <= cfg.tov_en;
         trim_report_en <= cfg.bto_en;
      end
   end

   // ************************************************************
   // Mode control
   // ************************************************************
   // Plain n/i exits wait one cycle so the response settles first; N/I switch at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= MODE_NORMAL;
         leave_pending <= 1'b0;
         leave_target <= MODE_NORMAL;
      end else begin
         leave_pending <= 1'b0;
         if (leave_pending) begin
            mode <= leave_target;
         end else if (go && chk == ST_OK) begin
            case (cmd_op)
               OP_ENTRY: mode <= MODE_MACHINE;
               OP_SVC_ENTRY: mode <= MODE_SERVICE;
               OP_LEAVE: mode <= MODE_NORMAL;
               OP_SVC_EXIT: begin
                  leave_target <= (arg0[7:0] == EXIT_I || arg0[7:0] == EXIT_I_NOW) ? MODE_INIT
                     : MODE_NORMAL;
                  if (arg0[7:0] == EXIT_N_NOW) mode <= MODE_NORMAL;
                  if (arg0[7:0] == EXIT_I_NOW || arg0[7:0] == EXIT_I) leave_pending <= 1'b1;
                  if (arg0[7:0] == EXIT_N) leave_pending <= 1'b1;
                  if (arg0[7:0] == EXIT_I_NOW) mode <= MODE_INIT;
               end
               default: mode <= mode;
            endcase
         end
      end
   end
endmodule // imu_cmd_handler

/* src/imu_cmd_pkg.sv */
// Package of the configuration command handler: offsets, fields, codes, config record.
// Assumes a single 40 MHz APB clock domain.
package imu_cmd_pkg;
   // ************************************************************
   // Register offsets (byte addresses)
   // ************************************************************
   localparam logic [7:0] OFF_CMD = 8'h00;
   localparam logic [7:0] OFF_ARG0 = 8'h04;
   localparam logic [7:0] OFF_ARG1 = 8'h08;
   localparam logic [7:0] OFF_CHAR = 8'h0c;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_RESULT = 8'h14;
   localparam logic [7:0] OFF_ERRIN = 8'h18;
   localparam logic [7:0] OFF_SAVES = 8'h1c;
   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CMD_CRC_LSB = 8;
   localparam int CMD_CNT_LSB = 16;
   localparam int CHAR_START_BIT = 8;
   localparam int ST_MODE_LSB = 4;
   localparam int ST_CRC_LSB = 8;
   localparam int ST_BUSY_BIT = 16;
   // ************************************************************
   // Checksum, counts, limits, identity
   // ************************************************************
   localparam logic [7:0] CRC_SEED = 8'hff;
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CHAR_DOLLAR = 8'h24;
   localparam logic [31:0] ENTRY_ACK_CRC = 32'h0000_00ea;
   localparam logic [15:0] SAVES_RESET = 16'h2710;
   localparam logic [15:0] TRIM_LIM_GYRO = 16'h2710;
   localparam logic [15:0] TRIM_LIM_ACC = 16'h03e8;
   localparam logic [15:0] TRIM_LIM_INC = 16'h00c8;
   localparam logic [31:0] ID_SERIAL = 32'h0000_1234; // Arbitrary value
   localparam logic [31:0] ID_NAME = 32'h0000_0001;   // Arbitrary value
   localparam logic [31:0] ID_PART = 32'h0000_0002;   // Arbitrary value
   localparam logic [31:0] ID_HW = 32'h0000_0003;     // Arbitrary value
   localparam logic [31:0] ID_FW = 32'h0000_0004;     // Arbitrary value
   localparam logic [31:0] ID_AXES = 32'h0000_01ff;
   localparam logic [31:0] ID_RANGES = 32'h0000_0005;
   localparam logic [31:0] ID_TX = 32'h0000_0006;
   // ************************************************************
   // Status codes, lowest wins
   // ************************************************************
   localparam logic [3:0] ST_OK = 4'h0;
   localparam logic [3:0] ST_INVALID = 4'h1;
   localparam logic [3:0] ST_BAD_CRC = 4'h2;
   localparam logic [3:0] ST_UNKNOWN = 4'h3;
   localparam logic [3:0] ST_PCOUNT = 4'h4;
   localparam logic [3:0] ST_BAD_PARAM = 4'h5;
   localparam logic [3:0] ST_SAVE_LIMIT = 4'h6;
   localparam logic [3:0] ST_SAVE_ERR = 4'h7;
   localparam logic [3:0] ST_CLAMPED = 4'h8;
   // ************************************************************
   // Modes and commands
   // ************************************************************
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_INIT = 2'b01,
      MODE_SERVICE = 2'b10,
      MODE_MACHINE = 2'b11
   } mode_t;
   typedef enum logic [7:0] {
      OP_ENTRY = 8'h01,
      OP_SVC_ENTRY = 8'h02,
      OP_QUERY = 8'h03,
      OP_ERRLOG = 8'h04,
      OP_SAVE = 8'h05,
      OP_SAVES_LEFT = 8'h06,
      OP_LEAVE = 8'h07,
      OP_SET = 8'h08,
      OP_TRIM_READ = 8'h09,
      OP_TRIM_ADJ = 8'h0a,
      OP_TRIM_SET = 8'h0b,
      OP_REF_READ = 8'h0c,
      OP_REF_SET = 8'h0d,
      OP_SVC_AUX = 8'h10,
      OP_SVC_SAVE = 8'h11,
      OP_SVC_EXIT = 8'h12,
      OP_SVC_RESTORE = 8'h13,
      OP_SVC_SYSCFG = 8'h14
   } op_t;
   // Field selectors of query and set
   localparam logic [4:0] F_RATE = 5'h00;
   localparam logic [4:0] F_GFILT = 5'h01;
   localparam logic [4:0] F_AFILT = 5'h02;
   localparam logic [4:0] F_IFILT = 5'h03;
   localparam logic [4:0] F_UFILT = 5'h04;
   localparam logic [4:0] F_DGRAM = 5'h05;
   localparam logic [4:0] F_GUNIT = 5'h06;
   localparam logic [4:0] F_AUNIT = 5'h07;
   localparam logic [4:0] F_IUNIT = 5'h08;
   localparam logic [4:0] F_GCOMP = 5'h09;
   localparam logic [4:0] F_SYSCFG = 5'h0a;
   localparam logic [4:0] F_AUX = 5'h0b;
   localparam logic [4:0] F_SERIAL = 5'h10;
   localparam logic [4:0] F_NAME = 5'h11;
   localparam logic [4:0] F_PART = 5'h12;
   localparam logic [4:0] F_HW = 5'h13;
   localparam logic [4:0] F_FW = 5'h14;
   localparam logic [4:0] F_AXES = 5'h15;
   localparam logic [4:0] F_RANGES = 5'h16;
   localparam logic [4:0] F_TX = 5'h17;
   // System configuration selectors (ASCII v, t, b)
   localparam logic [7:0] SYS_VOLT = 8'h76;
   localparam logic [7:0] SYS_TOV = 8'h74;
   localparam logic [7:0] SYS_BTO = 8'h62;
   // Exit targets (ASCII n, i, N, I)
   localparam logic [7:0] EXIT_N = 8'h6e;
   localparam logic [7:0] EXIT_I = 8'h69;
   localparam logic [7:0] EXIT_N_NOW = 8'h4e;
   localparam logic [7:0] EXIT_I_NOW = 8'h49;
   typedef struct packed {
      logic [2:0] rate;
      logic [2:0] gfilt;
      logic [2:0] afilt;
      logic [2:0] ifilt;
      logic [2:0] ufilt;
      logic [7:0] dgram;
      logic [3:0] gunit;
      logic [3:0] aunit;
      logic [3:0] iunit;
      logic [3:0] gcomp;
      logic volt_3v3;
      logic tov_en;
      logic bto_en;
      logic [15:0] aux_k1;
      logic [15:0] aux_k2;
      logic [8:0][15:0] trim;
      logic [31:0] ref_info;
   } cfg_t;
   localparam cfg_t CFG_FACTORY = '{rate: 3'h4, gfilt: 3'h4, afilt: 3'h4, ifilt: 3'h4,
      ufilt: 3'h4, dgram: 8'h93, gunit: 4'h0, aunit: 4'h0, iunit: 4'h0, gcomp: 4'h0,
      volt_3v3: 1'b0, tov_en: 1'b1, bto_en: 1'b1, aux_k1: 16'h0001, aux_k2: 16'h0000,
      trim: '0, ref_info: 32'h0000_0000};
endpackage

/* test/imu_cmd_chk.sv */
// Checker of bus timing and config outputs of the command handler.
// Assumes one pclk domain with presetn async active low.
`timescale 1ns/1ps
module imu_cmd_chk
   import imu_cmd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic flash_write,
   input wire cfg_t cfg,
   input wire logic volt_3v3,
   input wire logic strobe_en,
   input wire logic trim_report_en
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   rdy_answer_a: assert property (psel && !penable |=> pready) else $error("pready late");
   rdy_pulse_a: assert property (pready |=> !pready) else $error("pready held");
   err_unmap_a: assert property (psel && !penable && paddr > 8'h1c |=> pslverr) else $error("no pslverr");
   err_only_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("stray pslverr");
   idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");
   save_pulse_a: assert property (flash_write |=> !flash_write) else $error("flash_write held");
   volt_follow_a: assert property ($past(presetn) |-> volt_3v3 == $past(cfg.volt_3v3)) else $error("volt");
   strobe_follow_a: assert property ($past(presetn) |-> strobe_en == $past(cfg.tov_en)) else $error("strobe");
   trim_follow_a: assert property ($past(presetn) |-> trim_report_en == $past(cfg.bto_en)) else $error("trim");
endmodule // imu_cmd_chk
bind imu_cmd_handler imu_cmd_chk i_imu_cmd_chk (.*);

/* test/fault_src.sv */
// Stand-in for sensors and flash beside the handler: error events and flash faults.
// Assumes requests from the bench, replayed one cycle later like a real source.
`timescale 1ns/1ps
module fault_src (
   input wire logic pclk,
   input wire logic [31:0] ev_req,
   input wire logic fault_req,
   output logic [31:0] err_event,
   output logic flash_fault
);
   initial begin
      err_event = 32'h0;
      flash_fault = 1'b0;
   end
   always @(posedge pclk) begin
      err_event <= ev_req;
      flash_fault <= fault_req;
   end
endmodule // fault_src

/* test/tb_top.sv */
// Self-checking bench of the command handler over APB.
// Assumes the serial layer is replaced by direct character and command writes.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; $display("mismatch t=%0t %h %h", $time, a, b); end end
module tb_top
   import imu_cmd_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, flash_write;
   logic volt_3v3, strobe_en, trim_report_en, flash_fault, fault_req = 0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata, err_event, ev_req = 32'h0, r, res;
   logic e;
   logic [3:0] st;
   mode_t mode;
   cfg_t cfg;
   int errors = 0, comparisons = 0, cycles = 0, saves_seen = 0;
   imu_cmd_handler i_imu_cmd_handler (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .err_event(err_event), .flash_fault(flash_fault), .mode(mode), .cfg(cfg), .flash_write(flash_write),
      .volt_3v3(volt_3v3), .strobe_en(strobe_en), .trim_report_en(trim_report_en));
   fault_src i_fault_src (.pclk(pclk), .ev_req(ev_req), .fault_req(fault_req), .err_event(err_event),
      .flash_fault(flash_fault));
   initial forever #12.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (flash_write === 1'b1) saves_seen++;
      if (cycles == 5000) begin
         errors++;
         print_verdict();
      end
   end
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] s);
      logic [7:0] v;
      v = s ^ c;
      for (int i = 0; i < 8; i++) v = v[7] ? (v << 1) ^ 8'h07 : v << 1;
      return v;
   endfunction
   // Release one idle edge later so the next call never drives twice in a step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata; e = pslverr; psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask
   task automatic cmd(input op_t op, input logic [3:0] n, input logic [31:0] a0, a1, input logic [7:0] c0, bad);
      logic [7:0] crc;
      crc = crc8(8'h2c, crc8(c0, 8'hff));
      apb(1, OFF_ARG0, a0);
      apb(1, OFF_ARG1, a1);
      apb(1, OFF_CHAR, {23'h0, 1'b1, c0});
      apb(1, OFF_CHAR, 32'h0000_002c);
      apb(1, OFF_CMD, {12'h0, n, crc ^ bad, op});
      r = 32'h0001_0000;
      for (int i = 0; i < 20 && r[16] !== 1'b0; i++) apb(0, OFF_STATUS, 0);
      st = r[3:0];
      apb(0, OFF_RESULT, 0);
      res = r;
   endtask
   task automatic t_refuse();
      apb(0, 8'h40, 0);
      `CHK({e, r}, {1'b1, 32'h0})
      cmd(OP_ERRLOG, 0, 0, 0, 8'h24, 0); `CHK(st, ST_INVALID)
      cmd(OP_ENTRY, 0, 0, 0, 8'h24, 0); `CHK({st, res, mode}, {ST_OK, 32'd234, MODE_MACHINE})
      cmd(OP_SAVE, 0, 0, 0, 8'h78, 0); `CHK(st, ST_INVALID)
      cmd(OP_SAVE, 0, 0, 0, 8'h24, 8'h01); `CHK(st, ST_BAD_CRC)
      cmd(op_t'(8'h3f), 0, 0, 0, 8'h24, 0); `CHK(st, ST_UNKNOWN)
      cmd(OP_SET, 1, F_RATE, 1, 8'h24, 0); `CHK(st, ST_PCOUNT)
   endtask
   task automatic t_config();
      cmd(OP_SET, 2, F_SYSCFG, 32'h5, 8'h24, 0); `CHK({volt_3v3, strobe_en, trim_report_en}, 3'b101)
      cmd(OP_QUERY, 1, F_SERIAL, 0, 8'h24, 0); `CHK(res, ID_SERIAL)
      cmd(OP_SAVE, 0, 0, 0, 8'h24, 0); `CHK({st, saves_seen}, {ST_OK, 32'd1})
      cmd(OP_SAVES_LEFT, 0, 0, 0, 8'h24, 0); `CHK(res, {16'h0, SAVES_RESET - 16'h1})
      fault_req <= 1;
      cmd(OP_SAVE, 0, 0, 0, 8'h24, 0); `CHK(st, ST_SAVE_ERR)
      fault_req <= 0; ev_req <= 32'h0000_0005;
      @(posedge pclk) ev_req <= 32'h0;
      cmd(OP_ERRLOG, 0, 0, 0, 8'h24, 0); `CHK(res, 32'h5)
      cmd(OP_ERRLOG, 0, 0, 0, 8'h24, 0); `CHK(res, 32'h0)
      cmd(OP_TRIM_SET, 2, 32'h0100, 3, 8'h24, 0);
      cmd(OP_TRIM_ADJ, 2, 32'h0400, 3, 8'h24, 0); `CHK({st, cfg.trim[3]}, {ST_CLAMPED, TRIM_LIM_ACC})
      cmd(OP_REF_SET, 1, 32'hcafe, 0, 8'h24, 0);
      cmd(OP_REF_READ, 0, 0, 0, 8'h24, 0); `CHK(res, 32'hcafe)
      cmd(OP_LEAVE, 0, 0, 0, 8'h24, 0); `CHK(mode, MODE_NORMAL)
   endtask
   // Stored copy here has strobe off, aux at factory values
   task automatic t_service();
      cmd(OP_SVC_ENTRY, 0, 0, 0, 8'h24, 0);
      cmd(OP_SVC_AUX, 2, 32'h11, 32'h22, 8'h24, 0); `CHK({cfg.aux_k1, cfg.aux_k2}, 32'h0011_0022)
      cmd(OP_SVC_SYSCFG, 2, SYS_TOV, 1, 8'h24, 0); `CHK(strobe_en, 1'b1)
      cmd(OP_SVC_EXIT, 1, EXIT_I, 0, 8'h24, 0); `CHK({mode, strobe_en, cfg.aux_k1}, {MODE_INIT, 1'b0, 16'h0001})
      cmd(OP_SVC_ENTRY, 0, 0, 0, 8'h24, 0);
      cmd(OP_SVC_RESTORE, 0, 0, 0, 8'h24, 0); `CHK(cfg, CFG_FACTORY)
      cmd(OP_SVC_SAVE, 0, 0, 0, 8'h24, 0); `CHK({st, saves_seen}, {ST_OK, 32'd3})
      cmd(OP_SVC_SYSCFG, 2, SYS_VOLT, 1, 8'h24, 0); `CHK(volt_3v3, 1'b1)
      cmd(OP_SVC_SYSCFG, 2, SYS_BTO, 0, 8'h24, 0); `CHK(trim_report_en, 1'b0)
      cmd(OP_SVC_EXIT, 1, EXIT_N_NOW, 0, 8'h24, 0); `CHK({mode, volt_3v3}, {MODE_NORMAL, 1'b1})
      cmd(OP_SVC_ENTRY, 0, 0, 0, 8'h24, 0);
      cmd(OP_SVC_EXIT, 1, EXIT_N, 0, 8'h24, 0); `CHK({mode, volt_3v3}, {MODE_NORMAL, 1'b1})
   endtask
   task automatic print_verdict();
      if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_refuse();
      t_config();
      t_service();
      print_verdict();
   end
endmodule // tb_top
